// ===== hw/trace_axi_slave.sv
`timescale 1ns/1ns
`include "trace_params.svh"
module trace_axi_slave import trace_pkg::*; (
	input  wire logic        clk_i,
	input  wire logic        resetn_i,
	input  wire logic        ce_i,
	input  wire logic        awvalid_i,
	input  wire logic [7:0]  awaddr_i,
	output wire logic        awready_o,
	input  wire logic        wvalid_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic [3:0]  wstrb_i,
	output wire logic        wready_o,
	output wire logic        bvalid_o,
	output wire logic [1:0]  bresp_o,
	input  wire logic        bready_i,
	input  wire logic        arvalid_i,
	input  wire logic [7:0]  araddr_i,
	output wire logic        arready_o,
	output wire logic        rvalid_o,
	output wire logic [31:0] rdata_o,
	output wire logic [1:0]  rresp_o,
	input  wire logic        rready_i,
	trace_reg_if.slave_side  rb
);
	axi_state_type st_q;
	axi_state_type st_d;
	// readies drop with the clock enable so no beat is taken while frozen
	assign awready_o = ce_i && !st_q.aw_got && !st_q.bvalid;
	assign wready_o  = ce_i && !st_q.w_got && !st_q.bvalid;
	assign arready_o = ce_i && !st_q.rvalid;
	assign rb.wr_en   = ce_i && st_q.aw_got && st_q.w_got && !st_q.bvalid;
	assign rb.wr_addr = st_q.awaddr;
	assign rb.wr_data = st_q.wdata;
	assign rb.wr_strb = st_q.wstrb;
	assign rb.rd_en   = arvalid_i && arready_o;
	assign rb.rd_addr = araddr_i;
	assign bvalid_o = st_q.bvalid;
	assign bresp_o  = st_q.bresp;
	assign rvalid_o = st_q.rvalid;
	assign rdata_o  = st_q.rdata;
	assign rresp_o  = st_q.rresp;
	always_comb begin
		st_d = st_q;
		if (awvalid_i && awready_o) begin
			st_d.aw_got = 1'b1;
			st_d.awaddr = awaddr_i;
		end
		if (wvalid_i && wready_o) begin
			st_d.w_got = 1'b1;
			st_d.wdata = wdata_i;
			st_d.wstrb = wstrb_i;
		end
		if (rb.wr_en) begin
			st_d.aw_got = 1'b0;
			st_d.w_got  = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp  = rb.wr_err ? `TB_RESP_SLVERR : `TB_RESP_OKAY;
		end
		if (st_q.bvalid && bready_i) begin
			st_d.bvalid = 1'b0;
		end
		if (rb.rd_en) begin
			st_d.rvalid = 1'b1;
			st_d.rdata  = rb.rd_data;
			st_d.rresp  = rb.rd_err ? `TB_RESP_SLVERR : `TB_RESP_OKAY;
		end
		if (st_q.rvalid && rready_i) begin
			st_d.rvalid = 1'b0;
		end
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end
endmodule // trace_axi_slave

// ===== hw/trace_buffer_readout.sv
// Behaviour
// (RULE1) detail entry takes two lines, address then data; 32 entries at most
// (RULE2) line count steps twice per detail entry
// (RULE3) detail byte access: byte in data low byte, data high byte cleared
// (RULE4) word access: lower-address byte to byte1, higher-address byte to byte0
// (RULE5) line is 4+8+8 bits; detail data lines carry zero top field
// (RULE6) detail top field bit3 size (1 byte), bit2 direction (1 read)
// (RULE7) detail top field bits 1..0 hold address bits 17 and 16
// (RULE8) normal and loop: bit3 marks destination address; meaningless in pure counter mode
// (RULE9) bit2 marks vector destination, which forces the destination flag
// (RULE10) counter modes: top field bits 1..0 hold counter bits 17 and 16
// (RULE11) reads allowed only disarmed, origin selected and not secured
// (RULE12) arming locks reads; aligned word write to read port unlocks when disarmed
// (RULE13) byte or misaligned reads give zero and keep the read pointer
// (RULE14) lines come out oldest first; line count never drops on reads
// (RULE15) after a session pointer sits at oldest line, zero without overflow
// (RULE16) aligned write to high half rewinds pointer to oldest line
// (RULE17) first word of a line gives fields 1,0; second gives field 2 zero-extended
// (RULE18) reads while armed give invalid data and keep the pointer
// (RULE19) contents and count survive system reset; no origin select reads zero
// (RULE20) per-comparator tag select; hit at queue head; off during background debug
// (RULE21) begin: tag trigger starts trace, break after; end: break at trigger
// (RULE22) tagging ignores direction, size and data qualifiers
// (RULE23) 64 lines; begin alignment stays armed until 64 lines stored
// (RULE24) write pointer wraps over oldest; count saturates at depth
`timescale 1ns/1ns
`include "trace_params.svh"
module trace_buffer_readout import trace_pkg::*; (
	input  wire logic        CLK_SYS_I,
	input  wire logic        RESETN_I,
	input  wire logic        CE_I,
	input  wire logic        AWVALID_I,
	input  wire logic [7:0]  AWADDR_I,
	output wire logic        AWREADY_O,
	input  wire logic        WVALID_I,
	input  wire logic [31:0] WDATA_I,
	input  wire logic [3:0]  WSTRB_I,
	output wire logic        WREADY_O,
	output wire logic        BVALID_O,
	output wire logic [1:0]  BRESP_O,
	input  wire logic        BREADY_I,
	input  wire logic        ARVALID_I,
	input  wire logic [7:0]  ARADDR_I,
	output wire logic        ARREADY_O,
	output wire logic        RVALID_O,
	output wire logic [31:0] RDATA_O,
	output wire logic [1:0]  RRESP_O,
	input  wire logic        RREADY_I,
	input  wire logic        SECURED_I,
	input  wire logic        TRACE_VALID_I,
	output wire logic        TRACE_READY_O,
	input  wire logic [17:0] TRACE_ADDR_I,
	input  wire logic [7:0]  TRACE_LO_BYTE_I,
	input  wire logic [7:0]  TRACE_HI_BYTE_I,
	input  wire logic        TRACE_BYTE_I,
	input  wire logic        TRACE_READ_I,
	input  wire logic        TRACE_SRC_DEST_I,
	input  wire logic        TRACE_VECTOR_I,
	input  wire logic [1:0]  ADDR_MATCH_I,
	input  wire logic [1:0]  QUAL_MATCH_I,
	input  wire logic [1:0]  HEAD_REACHED_I,
	input  wire logic        BACKGROUND_DEBUG_I,
	output wire logic        BREAK_REQ_O,
	output wire logic        ARMED_O
);
	trace_state_type st_q;
	trace_state_type st_d;
	trace_reg_if     rb ();
	logic            tag_trig;
	logic            readable;
	logic            store_en;
	logic            word_wr;
	logic            wr_line_en;
	line_type        wr_line;
	logic [5:0]      oldest;
	logic [7:0]      wr_word;
	logic [7:0]      rd_word;
	logic            arm;
	logic            addr_store;
	logic            rewind;
	mode_type        mode;

	trace_axi_slave u_axi (
		.clk_i     (CLK_SYS_I),
		.resetn_i  (RESETN_I),
		.ce_i      (CE_I),
		.awvalid_i (AWVALID_I),
		.awaddr_i  (AWADDR_I),
		.awready_o (AWREADY_O),
		.wvalid_i  (WVALID_I),
		.wdata_i   (WDATA_I),
		.wstrb_i   (WSTRB_I),
		.wready_o  (WREADY_O),
		.bvalid_o  (BVALID_O),
		.bresp_o   (BRESP_O),
		.bready_i  (BREADY_I),
		.arvalid_i (ARVALID_I),
		.araddr_i  (ARADDR_I),
		.arready_o (ARREADY_O),
		.rvalid_o  (RVALID_O),
		.rdata_o   (RDATA_O),
		.rresp_o   (RRESP_O),
		.rready_i  (RREADY_I),
		.rb        (rb)
	);

	trace_tag_unit u_tag (
		.clk_i          (CLK_SYS_I),
		.resetn_i       (RESETN_I),
		.ce_i           (CE_I),
		.tag_sel_i      (st_q.ctl.cfg[`TB_TAG_LSB +: 2]),
		.addr_match_i   (ADDR_MATCH_I),
		.qual_match_i   (QUAL_MATCH_I),
		.head_reached_i (HEAD_REACHED_I),
		.bdm_i          (BACKGROUND_DEBUG_I),
		.trigger_o      (tag_trig)
	);

	assign arm      = st_q.ctl.cfg[`TB_ARM_BIT];
	assign mode     = mode_type'(st_q.ctl.cfg[`TB_MODE_LSB +: 2]);
	assign wr_word  = {rb.wr_addr[7:2], 2'b00};
	assign rd_word  = {rb.rd_addr[7:2], 2'b00};
	assign word_wr  = (rb.wr_addr[1:0] == 2'b00) && (rb.wr_strb == `TB_WORD_STRB);
	assign readable = !arm && st_q.ctl.cfg[`TB_ORIGIN_BIT] && !SECURED_I && !st_q.ctl.locked; // see (RULE11) see (RULE19)
	// begin alignment holds off storing until the trigger
	assign store_en = arm && st_q.ctl.cfg[`TB_ORIGIN_BIT] && (!st_q.ctl.cfg[`TB_ALIGN_BIT] || st_q.ctl.triggered);
	// a full count means the pointer has wrapped and now sits on the oldest line
	assign oldest   = (st_q.keep.count == `TB_DEPTH) ? st_q.keep.wr_ptr : 6'h00; // see (RULE15) see (RULE24)
	assign addr_store = CE_I && (st_q.ctl.fsm == CAP_IDLE) && TRACE_VALID_I && store_en && (mode == MODE_DETAIL);
	assign rewind   = rb.wr_en && word_wr && (wr_word == `TB_PORT_HIGH_OFS);
	// ready follows the clock enable so a frozen block takes no capture handshake
	assign TRACE_READY_O = CE_I && (st_q.ctl.fsm == CAP_IDLE);
	assign BREAK_REQ_O   = st_q.ctl.brk;
	assign ARMED_O       = arm;

	always_comb begin
		st_d = st_q;
		st_d.ctl.brk = 1'b0;
		wr_line_en = 1'b0;
		wr_line = '0;
		rb.wr_err = 1'b0;
		rb.rd_err = 1'b0;
		rb.rd_data = 32'h0000_0000;
		if (rb.wr_en) begin
			case (wr_word)
				`TB_CTRL_OFS: begin
					if (rb.wr_strb[0]) begin
						if (rb.wr_data[`TB_ARM_BIT]) begin
							st_d.ctl.locked = 1'b1; // see (RULE12)
							if (!arm) begin
								st_d.keep.count = 7'h00;
								st_d.keep.wr_ptr = 6'h00;
								st_d.ctl.sess = 7'h00;
								st_d.ctl.triggered = 1'b0;
							end
						end
						st_d.ctl.cfg = rb.wr_data[7:0];
					end
				end
				`TB_PORT_OFS: begin
					if (word_wr && !arm) begin
						st_d.ctl.locked = 1'b0; // see (RULE12)
						st_d.ctl.rd_ptr = oldest; // see (RULE19)
						st_d.ctl.half = 1'b0;
					end
				end
				`TB_PORT_HIGH_OFS: begin
					if (word_wr) begin
						st_d.ctl.rd_ptr = oldest; // see (RULE16)
						st_d.ctl.half = 1'b0;
					end
				end
				`TB_COUNT_OFS: begin
				end
				default: begin
					rb.wr_err = 1'b1;
				end
			endcase
		end
		if (rb.rd_en) begin
			case (rd_word)
				`TB_CTRL_OFS: begin
					rb.rd_data = {24'h00_0000, st_q.ctl.cfg};
				end
				`TB_COUNT_OFS: begin
					rb.rd_data = {25'h000_0000, st_q.keep.count}; // see (RULE14)
				end
				`TB_PORT_OFS: begin
					// locked, armed or misaligned reads all answer zero and leave the pointer
					if (rb.rd_addr[1:0] == 2'b00 && readable) begin // see (RULE13) see (RULE18)
						if (!st_q.ctl.half) begin
							rb.rd_data = {16'h0000, st_q.keep.lines[st_q.ctl.rd_ptr][15:0]}; // see (RULE17)
							st_d.ctl.half = 1'b1;
						end else begin
							rb.rd_data = {28'h000_0000, st_q.keep.lines[st_q.ctl.rd_ptr][19:16]}; // see (RULE17)
							st_d.ctl.half = 1'b0;
							st_d.ctl.rd_ptr = st_q.ctl.rd_ptr + 6'h01; // see (RULE14)
						end
					end
				end
				`TB_PORT_HIGH_OFS: begin
				end
				default: begin
					rb.rd_err = 1'b1;
				end
			endcase
		end
		// a rewind in the same cycle as a port read wins, so a restart always lands on the oldest line
		if (rewind) begin
			st_d.ctl.rd_ptr = oldest; // see (RULE16)
			st_d.ctl.half = 1'b0;
		end
		case (st_q.ctl.fsm)
			CAP_IDLE: begin
				if (TRACE_VALID_I && store_en) begin
					wr_line_en = 1'b1;
					if (mode == MODE_DETAIL) begin
						wr_line = {TRACE_BYTE_I, TRACE_READ_I, TRACE_ADDR_I}; // see (RULE6) see (RULE7)
						if (TRACE_BYTE_I) begin
							st_d.ctl.pend = {12'h000, TRACE_LO_BYTE_I}; // see (RULE3)
						end else begin
							st_d.ctl.pend = {4'h0, TRACE_LO_BYTE_I, TRACE_HI_BYTE_I}; // see (RULE4) see (RULE5)
						end
						st_d.ctl.fsm = CAP_DATA; // see (RULE1)
					end else if (mode == MODE_PURE_PC) begin
						wr_line = {2'b00, TRACE_ADDR_I}; // see (RULE10)
					end else begin
						wr_line = {TRACE_SRC_DEST_I | TRACE_VECTOR_I, TRACE_VECTOR_I, TRACE_ADDR_I}; // see (RULE8) see (RULE9)
					end
				end
			end
			CAP_DATA: begin
				// data line is always finished, even if the session ended meanwhile
				wr_line_en = 1'b1;
				wr_line = st_q.ctl.pend; // see (RULE1) see (RULE2)
				st_d.ctl.fsm = CAP_IDLE;
			end
			default: begin
				st_d.ctl.fsm = CAP_IDLE;
			end
		endcase
		if (wr_line_en) begin
			st_d.keep.lines[st_d.keep.wr_ptr] = wr_line; // see (RULE5)
			st_d.keep.wr_ptr = st_d.keep.wr_ptr + 6'h01; // see (RULE24)
			if (st_d.keep.count != `TB_DEPTH) begin
				st_d.keep.count = st_d.keep.count + 7'h01; // see (RULE2) see (RULE24)
			end
			if (st_d.ctl.sess != `TB_DEPTH) begin
				st_d.ctl.sess = st_d.ctl.sess + 7'h01;
			end
		end
		if (tag_trig && arm) begin
			if (st_q.ctl.cfg[`TB_ALIGN_BIT]) begin
				if (!st_q.ctl.triggered) begin
					st_d.ctl.triggered = 1'b1; // see (RULE21)
					st_d.ctl.sess = 7'h00;
				end
			end else begin
				st_d.ctl.cfg[`TB_ARM_BIT] = 1'b0; // see (RULE21)
				st_d.ctl.brk = st_q.ctl.cfg[`TB_BRK_BIT];
			end
		end
		if (arm && st_q.ctl.triggered && st_d.ctl.sess == `TB_DEPTH && st_d.ctl.fsm == CAP_IDLE) begin
			st_d.ctl.cfg[`TB_ARM_BIT] = 1'b0; // see (RULE23)
			st_d.ctl.triggered = 1'b0;
			st_d.ctl.brk = st_q.ctl.cfg[`TB_BRK_BIT]; // see (RULE21)
		end
	end

	// buffer lines, count and write pointer have no reset so a session survives a system reset
	always_ff @(posedge CLK_SYS_I or negedge RESETN_I) begin
		if (!RESETN_I) begin
			st_q.ctl <= '0;
			st_q.ctl.cfg <= `TB_CTRL_RST;
			st_q.ctl.fsm <= CAP_IDLE;
			st_q.ctl.locked <= 1'b1; // see (RULE19)
		end else if (CE_I) begin
			st_q <= st_d;
		end
	end

	default clocking cb @(posedge CLK_SYS_I); endclocking
	default disable iff (!RESETN_I);

	detail_pair_a: assert property (addr_store |=> st_q.ctl.fsm == CAP_DATA) // see (RULE1)
		else $error("detail entry without data line");
	count_twice_a: assert property (addr_store && st_q.keep.count < 7'h3E ##1 CE_I // see (RULE2)
		|=> st_q.keep.count == $past(st_q.keep.count, 2) + 7'h02)
		else $error("count not stepped twice");
	byte_clear_a: assert property (addr_store && TRACE_BYTE_I // see (RULE3)
		|=> st_q.ctl.pend == {12'h000, $past(TRACE_LO_BYTE_I)})
		else $error("byte data line wrong");
	word_order_a: assert property (addr_store && !TRACE_BYTE_I // see (RULE4)
		|=> st_q.ctl.pend == {4'h0, $past(TRACE_LO_BYTE_I), $past(TRACE_HI_BYTE_I)})
		else $error("word byte order wrong");
	addr_line_a: assert property (addr_store // see (RULE6) see (RULE7)
		|=> st_q.keep.lines[$past(st_q.keep.wr_ptr)] == {$past(TRACE_BYTE_I), $past(TRACE_READ_I), $past(TRACE_ADDR_I)})
		else $error("detail address line wrong");
	data_zero_a: assert property (CE_I && st_q.ctl.fsm == CAP_DATA // see (RULE5)
		|=> st_q.keep.lines[$past(st_q.keep.wr_ptr)][19:16] == 4'h0)
		else $error("data line top field not zero");
	vector_flag_a: assert property (CE_I && st_q.ctl.fsm == CAP_IDLE && TRACE_VALID_I && store_en // see (RULE9)
		&& (mode == MODE_NORMAL || mode == MODE_LOOP) && TRACE_VECTOR_I
		|=> st_q.keep.lines[$past(st_q.keep.wr_ptr)][19:18] == 2'b11)
		else $error("vector flag without destination flag");
	locked_zero_a: assert property (rb.rd_en && rd_word == `TB_PORT_OFS && !readable // see (RULE11)
		|-> rb.rd_data == 32'h0000_0000)
		else $error("blocked read returned data");
	misalign_hold_a: assert property (rb.rd_en && rd_word == `TB_PORT_OFS && rb.rd_addr[1:0] != 2'b00 // see (RULE13)
		|-> rb.rd_data == 32'h0000_0000 ##1 $stable(st_q.ctl.rd_ptr) && $stable(st_q.ctl.half))
		else $error("misaligned read moved pointer");
	armed_hold_a: assert property (rb.rd_en && rd_word == `TB_PORT_OFS && arm // see (RULE18)
		|=> $stable(st_q.ctl.rd_ptr))
		else $error("armed read moved pointer");
	second_half_a: assert property (rb.rd_en && rd_word == `TB_PORT_OFS && readable // see (RULE17)
		&& rb.rd_addr[1:0] == 2'b00 && st_q.ctl.half |-> rb.rd_data[31:4] == 28'h000_0000 ##1 !st_q.ctl.half)
		else $error("second word not zero extended");
	restart_ptr_a: assert property (rb.wr_en && wr_word == `TB_PORT_HIGH_OFS && word_wr // see (RULE16)
		|=> st_q.ctl.rd_ptr == $past(oldest) && !st_q.ctl.half)
		else $error("pointer not rewound");
	count_sat_a: assert property (CE_I && wr_line_en && st_q.keep.count == `TB_DEPTH // see (RULE24)
		|=> st_q.keep.count == `TB_DEPTH)
		else $error("count left saturation");
	end_break_a: assert property (CE_I && tag_trig && arm && !st_q.ctl.cfg[`TB_ALIGN_BIT] // see (RULE21)
		|=> !arm && st_q.ctl.brk == $past(st_q.ctl.cfg[`TB_BRK_BIT]))
		else $error("end trigger did not stop");
	begin_hold_a: assert property (CE_I && arm && st_q.ctl.triggered && st_q.ctl.cfg[`TB_ALIGN_BIT] // see (RULE23)
		&& st_q.ctl.sess < 7'h3F && !rb.wr_en |=> arm)
		else $error("begin session stopped early");
	begin_stop_a: assert property (CE_I && arm && st_q.ctl.triggered && wr_line_en // see (RULE21) see (RULE23)
		&& st_q.ctl.sess == 7'h3F && (mode != MODE_DETAIL || st_q.ctl.fsm == CAP_DATA)
		|=> !arm && st_q.ctl.brk == $past(st_q.ctl.cfg[`TB_BRK_BIT]))
		else $error("begin session did not stop at full");
	count_hold_a: assert property (CE_I && rb.rd_en && !rb.wr_en && !wr_line_en // see (RULE14)
		|=> st_q.keep.count == $past(st_q.keep.count))
		else $error("read changed line count");

	detail_store_c: cover property (addr_store ##1 st_q.ctl.fsm == CAP_DATA);
	high_read_c: cover property (rb.rd_en && readable && st_q.ctl.half);
	overflow_c: cover property (wr_line_en && st_q.keep.count == `TB_DEPTH);
	break_c: cover property (st_q.ctl.brk && st_q.ctl.cfg[`TB_ALIGN_BIT]);
	begin_trig_c: cover property (tag_trig && arm && st_q.ctl.cfg[`TB_ALIGN_BIT]);
endmodule // trace_buffer_readout

// ===== hw/trace_tag_unit.sv
`timescale 1ns/1ns
module trace_tag_unit import trace_pkg::*; (
	input  wire logic       clk_i,
	input  wire logic       resetn_i,
	input  wire logic       ce_i,
	input  wire logic [1:0] tag_sel_i,
	input  wire logic [1:0] addr_match_i,
	input  wire logic [1:0] qual_match_i,
	input  wire logic [1:0] head_reached_i,
	input  wire logic       bdm_i,
	output wire logic       trigger_o
);
	tag_state_type st_q;
	tag_state_type st_d;
	logic [1:0]    fire;
	assign trigger_o = st_q.trig;
	always_comb begin
		st_d = st_q;
		fire = 2'b00;
		for (int k = 0; k < 2; k++) begin
			// tagged compares ignore direction, size and data qualifiers
			if (!tag_sel_i[k]) begin
				fire[k] = addr_match_i[k] && qual_match_i[k]; // see (RULE20) see (RULE22)
			end else if (bdm_i) begin
				st_d.pending[k] = 1'b0; // see (RULE20)
			end else begin
				fire[k] = st_q.pending[k] && head_reached_i[k]; // see (RULE20)
				if (fire[k]) begin
					st_d.pending[k] = 1'b0;
				end
				if (addr_match_i[k]) begin
					st_d.pending[k] = 1'b1; // see (RULE22)
				end
			end
		end
		st_d.trig = |fire;
	end
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_q <= '0;
		end else if (ce_i) begin
			st_q <= st_d;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	tag_block_a: assert property (ce_i && bdm_i |=> (st_q.pending & $past(tag_sel_i)) == 2'b00) // see (RULE20)
		else $error("tag kept while background debug active");
	tag_noqual_a: assert property (ce_i && !bdm_i && tag_sel_i[0] && addr_match_i[0] && !qual_match_i[0]
		|=> st_q.pending[0]) // see (RULE22)
		else $error("tagged match blocked by qualifier");
endmodule // trace_tag_unit

// ===== shared/trace_params.svh
`ifndef TRACE_PARAMS_SVH
`define TRACE_PARAMS_SVH
`define TB_CTRL_OFS 8'h00
`define TB_COUNT_OFS 8'h04
`define TB_PORT_OFS 8'h08
`define TB_PORT_HIGH_OFS 8'h0C
`define TB_ARM_BIT 0
`define TB_ORIGIN_BIT 1
`define TB_MODE_LSB 2
`define TB_ALIGN_BIT 4
`define TB_BRK_BIT 5
`define TB_TAG_LSB 6
`define TB_CTRL_RST 8'h00
`define TB_DEPTH 7'h40
`define TB_WORD_STRB 4'h3
`define TB_RESP_OKAY 2'h0
`define TB_RESP_SLVERR 2'h2
`endif

// ===== shared/trace_pkg.sv
package trace_pkg;
	typedef logic [19:0] line_type;
	typedef enum logic [1:0] {
		MODE_NORMAL  = 2'h0,
		MODE_LOOP    = 2'h1,
		MODE_DETAIL  = 2'h2,
		MODE_PURE_PC = 2'h3
	} mode_type;
	typedef enum logic [1:0] {
		CAP_IDLE = 2'b01,
		CAP_DATA = 2'b10
	} cap_state_type;
	typedef struct packed {
		line_type [63:0] lines;
		logic [6:0]      count;
		logic [5:0]      wr_ptr;
	} keep_type;
	typedef struct packed {
		logic [7:0]    cfg;
		logic          locked;
		logic          triggered;
		logic [6:0]    sess;
		logic [5:0]    rd_ptr;
		logic          half;
		cap_state_type fsm;
		line_type      pend;
		logic          brk;
	} ctl_type;
	typedef struct packed {
		keep_type keep;
		ctl_type  ctl;
	} trace_state_type;
	typedef struct packed {
		logic        aw_got;
		logic [7:0]  awaddr;
		logic        w_got;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axi_state_type;
	typedef struct packed {
		logic [1:0] pending;
		logic       trig;
	} tag_state_type;
endpackage

// ===== shared/trace_reg_if.sv
`timescale 1ns/1ns
interface trace_reg_if;
	logic        wr_en;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_err;
	logic        rd_en;
	logic [7:0]  rd_addr;
	logic [31:0] rd_data;
	logic        rd_err;
	modport slave_side (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, input wr_err, rd_data, rd_err);
	modport regs_side (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr, output wr_err, rd_data, rd_err);
endinterface

// ===== verif/trace_buffer_readout_test.sv
`timescale 1ns/1ns
module trace_buffer_readout_test;
	logic        clk, reset_n, secured, awvalid, wvalid, bready, arvalid, rready, background_debug;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rv;
	logic [3:0]  wstrb, info;
	logic [1:0]  am, hr, rr, qm, br;
	logic [17:0] taddr;
	logic [7:0]  tlo, thi;
	logic        tvalid;
	wire         awready, wready, bvalid, arready, rvalid, tready, brk, armed;
	wire  [1:0]  bresp, rresp;
	wire  [31:0] rdata;
	int          fails, num_checks;
	logic [31:0] exp_d [8] = '{32'h1234, 32'hE, 32'hAB, 32'h0, 32'h5678, 32'h1, 32'h1122, 32'h0};
	initial clk = 1'b0;
	initial {reset_n, secured, awvalid, wvalid, bready, arvalid, rready, background_debug} = '0;
	initial {awaddr, araddr, wdata, wstrb, am, hr, qm} = '0;
	always #25 clk = ~clk;
	trace_buffer_readout DUT (.CLK_SYS_I(clk), .RESETN_I(reset_n), .CE_I(1'b1), .AWVALID_I(awvalid),
		.AWADDR_I(awaddr), .AWREADY_O(awready), .WVALID_I(wvalid), .WDATA_I(wdata), .WSTRB_I(wstrb),
		.WREADY_O(wready), .BVALID_O(bvalid), .BRESP_O(bresp), .BREADY_I(bready), .ARVALID_I(arvalid),
		.ARADDR_I(araddr), .ARREADY_O(arready), .RVALID_O(rvalid), .RDATA_O(rdata), .RRESP_O(rresp),
		.RREADY_I(rready), .SECURED_I(secured), .TRACE_VALID_I(tvalid), .TRACE_READY_O(tready),
		.TRACE_ADDR_I(taddr), .TRACE_LO_BYTE_I(tlo), .TRACE_HI_BYTE_I(thi), .TRACE_BYTE_I(info[3]),
		.TRACE_READ_I(info[2]), .TRACE_SRC_DEST_I(info[1]), .TRACE_VECTOR_I(info[0]), .ADDR_MATCH_I(am),
		.QUAL_MATCH_I(qm), .HEAD_REACHED_I(hr), .BACKGROUND_DEBUG_I(background_debug), .BREAK_REQ_O(brk), .ARMED_O(armed));
	trace_cpu_model cpu (.clk_i(clk), .ready_i(tready), .valid_o(tvalid), .addr_o(taddr), .lo_o(tlo),
		.hi_o(thi), .info_o(info));
	task automatic chk(input string n, input logic [31:0] e, g);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic na, nw, nb;
		@(posedge clk);
		{awvalid, awaddr, wvalid, wdata, wstrb, bready} <= {1'b1, a, 1'b1, d, s, 1'b1};
		while (1) begin
			@(negedge clk);
			na = awvalid && awready;
			nw = wvalid && wready;
			nb = bvalid;
			br = bresp;
			@(posedge clk);
			if (na) awvalid <= 1'b0;
			if (nw) wvalid <= 1'b0;
			if (nb) break;
		end
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		logic na, nb;
		@(posedge clk);
		{arvalid, araddr, rready} <= {1'b1, a, 1'b1};
		while (1) begin
			@(negedge clk);
			na = arvalid && arready;
			nb = rvalid;
			{rv, rr} = {rdata, rresp};
			@(posedge clk);
			if (na) arvalid <= 1'b0;
			if (nb) break;
		end
		rready <= 1'b0;
	endtask
	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(n, e, rv);
	endtask
	task automatic pul(input logic [1:0] m, h, input logic b);
		@(posedge clk);
		{am, hr, background_debug} <= {m, h, b};
		@(posedge clk);
		{am, hr, background_debug} <= '0;
	endtask
	task automatic brk_wait(input logic e);
		logic got;
		got = 1'b0;
		repeat (10) begin
			@(negedge clk);
			got |= brk;
		end
		chk("break", 32'(e), 32'(got));
	endtask
	// one-entry session: arm, capture, disarm, unlock, read the line back
	task automatic sess(input logic [7:0] c, input logic [17:0] a, input logic [3:0] f, input logic [31:0] f2);
		wr(8'h00, {24'h0, c}, 4'h1);
		cpu.send(a, 8'h00, 8'h00, f, 1);
		wr(8'h00, {24'h0, c & 8'hFE}, 4'h1);
		wr(8'h08, 32'h0, 4'h3);
		rdc("pc word", 8'h08, {16'h0, a[15:0]});
		rdc("pc info", 8'h08, f2);
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		give_verdict;
	end
	initial begin
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		wr(8'h00, 32'h0000_000B, 4'h1);
		chk("write okay", 32'h0, 32'(br));
		cpu.send(18'h2_1234, 8'hAB, 8'h55, 4'b1100, 0);
		cpu.send(18'h1_5678, 8'h11, 8'h22, 4'b0000, 2);
		wr(8'h00, 32'h0000_000A, 4'h1);
		rdc("count", 8'h04, 32'h4);
		rdc("locked", 8'h08, 32'h0);
		wr(8'h08, 32'h0, 4'h3);
		for (int k = 0; k < 8; k++)
			rdc("detail", 8'h08, exp_d[k]);
		wr(8'h0C, 32'h0, 4'h3);
		rdc("rewind", 8'h08, 32'h1234);
		rdc("misaligned", 8'h09, 32'h0);
		rdc("kept", 8'h08, 32'hE);
		@(posedge clk) secured <= 1'b1;
		rdc("secured", 8'h08, 32'h0);
		@(posedge clk) secured <= 1'b0;
		rdc("after", 8'h08, 32'hAB);
		$display("test detail done");
		wr(8'h00, 32'h0000_0003, 4'h1);
		for (int i = 0; i < 65; i++)
			cpu.send({2'b11, 16'(i)}, 8'h00, 8'h00, {2'b00, i[1] | i[0], i[0]}, 0);
		rdc("armed", 8'h08, 32'h0);
		wr(8'h00, 32'h0000_0002, 4'h1);
		rdc("full", 8'h04, 32'd64);
		wr(8'h08, 32'h0, 4'h3);
		for (int k = 1; k < 3; k++) begin
			rdc("oldest", 8'h08, 32'(k));
			rdc("flags", 8'h08, {28'h0, |k[1:0], k[0], 2'b11});
		end
		$display("test overflow done");
		@(posedge clk) reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		rdc("kept count", 8'h04, 32'd64);
		rdc("no origin", 8'h08, 32'h0);
		wr(8'h00, 32'h0000_0002, 4'h1);
		wr(8'h08, 32'h0, 4'h3);
		rdc("kept line", 8'h08, 32'h1);
		$display("test reset done");
		sess(8'h07, 18'h2_0040, 4'b0010, 32'hA);
		sess(8'h0F, 18'h1_0077, 4'b0011, 32'h1);
		$display("test modes done");
		wr(8'h00, 32'h0000_006F, 4'h1);
		pul(2'b01, 2'b00, 1'b0);
		pul(2'b00, 2'b00, 1'b1);
		pul(2'b00, 2'b01, 1'b0);
		pul(2'b10, 2'b00, 1'b0);
		brk_wait(1'b0);
		chk("still armed", 32'h1, 32'(armed));
		pul(2'b01, 2'b00, 1'b0);
		pul(2'b00, 2'b01, 1'b0);
		brk_wait(1'b1);
		chk("disarmed", 32'h0, 32'(armed));
		@(posedge clk) qm <= 2'b10;
		wr(8'h00, 32'h0000_0033, 4'h1);
		cpu.send(18'h0_0100, 8'h00, 8'h00, 4'b0000, 0);
		pul(2'b10, 2'b00, 1'b0);
		brk_wait(1'b0);
		for (int i = 0; i < 63; i++)
			cpu.send({2'b00, 16'(i)}, 8'h00, 8'h00, 4'b0000, 0);
		rdc("begin count", 8'h04, 32'd63);
		chk("begin armed", 32'h1, 32'(armed));
		cpu.send(18'h0_0040, 8'h00, 8'h00, 4'b0000, 0);
		brk_wait(1'b1);
		chk("begin done", 32'h0, 32'(armed));
		rd(8'h10);
		chk("unmapped", 32'h2, 32'(rr));
		wr(8'h10, 32'h0, 4'hF);
		chk("unmapped write", 32'h2, 32'(br));
		$display("test tag done");
		give_verdict;
	end
endmodule // trace_buffer_readout_test

// ===== verif/trace_cpu_model.sv
`timescale 1ns/1ns
module trace_cpu_model (
	input  wire logic        clk_i,
	input  wire logic        ready_i,
	output logic             valid_o,
	output logic [17:0]      addr_o,
	output logic [7:0]       lo_o,
	output logic [7:0]       hi_o,
	output logic [3:0]       info_o
);
	initial {valid_o, addr_o, lo_o, hi_o, info_o} = '0;
	// info is {byte, read, destination, vector}; gap gives a slow source
	task automatic send(input logic [17:0] a, input logic [7:0] l, h, input logic [3:0] f, input int gap);
		logic tk;
		repeat (gap + 1) @(posedge clk_i);
		{valid_o, addr_o, lo_o, hi_o, info_o} <= {1'b1, a, l, h, f};
		tk = 1'b0;
		while (!tk) begin
			@(negedge clk_i);
			tk = ready_i;
			@(posedge clk_i);
		end
		// released fields show the inverse so stale values never look valid
		{valid_o, addr_o, lo_o, hi_o, info_o} <= {1'b0, ~a, ~l, ~h, ~f};
	endtask
endmodule // trace_cpu_model
